// *** design/sadc_top.sv ***
// Scanning converter controller: register slave, scan sequencer, sample store.
// Assumes the converter answers each start with one done pulse and data.
//
// Behaviour
// - Host reaches all registers and samples as a bus slave; narrow reads allowed.
// - Interrupt on programmable level 1..7; acknowledge releases it, returns vector.
// - Interrupt at buffer end, and also at midpoint when selected by software.
// - Optional interrupt after programmed count of 1..65535 samples.
// - Acknowledge vector comes from a writable vector register.
// - Data-ready flag set when buffer full, or half full if midpoint is selected.
// - Interval timer gives periodic triggers up to 687 seconds.
// - System reset or write to soft-reset address resets the board.
// - Reset gives autoscan, 64-channel block and buffer, unity gain, 100 kHz.
// - Calibration lasting 41 ms from reset precedes acquisition.
// - Gain x1/x10 global or per channel, switched per sample.
// - Panel light on at reset, stays until software clears it.
// - Read-only board identification register with fixed code.
// - Block size selectable: 1, 8, 16, 32 or 64 channels.
// - Store holds 1024 words, 16 per channel for 64 channels.
// - Host reads the store any time without halting scans.
// - Scanning starts by itself after reset; software may change modes.
// - External trigger input starts acquisition.
// - Conversion rate selectable, at most 100 kSPS.
// - Output coding two's complement or offset binary.
// - Auto and single scans begin at channel zero and advance in order.
// - Block size set through a configuration register.
`timescale 1ns/100ps
`default_nettype none
module sadc_top #(
   parameter int CAL_CYCLES = sadc_pkg::CAL_CYC,
   parameter logic [31:0] BOARD_ID = sadc_pkg::BOARD_ID_DEF // Arbitrary value
) (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   output logic conv_start_out,
   output sadc_pkg::sadc_cmd_t adc_cmd_out,
   input wire logic conv_done_in,
   input wire logic [15:0] conv_data_in,
   input wire logic ext_trig_in,
   output logic cal_busy_out,
   output logic led_out,
   output logic irq_req_out,
   output logic [2:0] irq_level_out,
   input wire logic iack_in,
   input wire logic [2:0] iack_level_in,
   output logic [7:0] irq_vector_out
);
   import sadc_pkg::*;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [5:0] blk_last(input logic [2:0] code);
      case (code)
         3'h0: blk_last = 6'h00;
         3'h1: blk_last = 6'h07;
         3'h2: blk_last = 6'h0F;
         3'h3: blk_last = 6'h1F;
         default: blk_last = 6'h3F;
      endcase
   endfunction : blk_last

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic srst_reg, rst;
   logic [1:0] dp_reg;
   logic [12:0] da_reg;
   logic dw_reg;
   logic [31:0] rd_next;
   logic rdy_reg, led_reg, twos_reg, irqen_reg, mid_reg, cnten_reg, gglb_reg, gx10_reg;
   logic start_reg;
   sadc_scan_t scan_reg;
   sadc_trig_t trig_reg;
   logic [2:0] blk_reg;
   logic [5:0] rch_reg;
   logic [15:0] rate_reg, count_reg, samp_reg, pace_reg;
   logic [31:0] timer_reg, tcnt_reg;
   logic [6:0] pre_reg;
   logic [7:0] vec_reg;
   logic [2:0] lvl_reg;
   logic [63:0] gain_reg;
   logic [15:0] mem [1024];
   logic [3:0] wptr [64];
   sadc_state_t st_reg;
   logic [22:0] cal_reg;
   logic active_reg, ext_q_reg;
   logic [5:0] ch_reg;
   logic [3:0] pass_reg;
   logic irq_reg;
   logic wr, trig, tmr_exp, pass_end, buf_evt, cnt_evt, irq_evt, ack, issue;
   logic [5:0] conv_ch;
   logic [15:0] sample;

   assign rst = !rst_n_in || srst_reg;
   assign wr = (dp_reg == 2'h2) && dw_reg;
   assign hreadyout_out = (dp_reg != 2'h1);
   assign hresp_out = 1'b0;

   // ----------------------------------------
   // Bus slave: one wait state, data from flops
   // ----------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (rst) begin
         dp_reg <= 2'h0;
         da_reg <= 13'h0000;
         dw_reg <= 1'b0;
         hrdata_out <= 32'h00000000;
      end else if (ce_in) begin
         if (dp_reg == 2'h1) begin
            dp_reg <= 2'h2;
            hrdata_out <= rd_next;
         end else if (hsel_in && htrans_in[1] && hready_in) begin
            dp_reg <= 2'h1;
            da_reg <= {haddr_in[12:2], 2'b00};
            dw_reg <= hwrite_in;
         end else begin
            dp_reg <= 2'h0;
         end
      end
   end

   always_comb begin
      rd_next = 32'h00000000;
      if (da_reg >= A_BUF) begin
         rd_next = {16'h0000, mem[da_reg[11:2]]};
      end else if (da_reg >= A_LATEST && da_reg < A_LATEST + 13'h0100) begin
         rd_next = {16'h0000, mem[{da_reg[7:2], wptr[da_reg[7:2]] - 4'h1}]};
      end else begin
         case (da_reg)
            A_CSR: rd_next = 32'({gx10_reg, gglb_reg, cnten_reg, mid_reg, irqen_reg,
                     cal_busy_out, 1'b0, trig_reg, scan_reg, twos_reg, led_reg, rdy_reg});
            A_CCR: rd_next = 32'({rch_reg, 5'h00, blk_reg});
            A_RATE: rd_next = {16'h0000, rate_reg};
            A_TIMER: rd_next = timer_reg;
            A_COUNT: rd_next = {16'h0000, count_reg};
            A_VEC: rd_next = 32'({lvl_reg, vec_reg});
            A_GAIN_LO: rd_next = gain_reg[31:0];
            A_GAIN_HI: rd_next = gain_reg[63:32];
            A_BID: rd_next = BOARD_ID;
            default: rd_next = 32'h00000000;
         endcase
      end
   end

   // Soft reset is held off the synchronous clear it drives, so it lasts one cycle
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         srst_reg <= 1'b0;
      end else begin
         srst_reg <= ce_in && wr && da_reg == A_SRST;
      end
   end

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (rst) begin
         scan_reg <= SCAN_AUTO;
         trig_reg <= TRIG_FREE;
         blk_reg <= BLK_RST;
         rate_reg <= RATE_RST;
         gglb_reg <= 1'b1;
         gx10_reg <= 1'b0;
         gain_reg <= 64'h0;
         twos_reg <= 1'b0;
         irqen_reg <= 1'b0;
         mid_reg <= 1'b0;
         cnten_reg <= 1'b0;
         start_reg <= 1'b0;
         rch_reg <= 6'h00;
         timer_reg <= TIMER_RST;
         count_reg <= COUNT_RST;
         vec_reg <= VEC_RST;
         lvl_reg <= LVL_RST;
      end else if (ce_in) begin
         start_reg <= wr && da_reg == A_CSR && hwdata_in[CSR_START];
         if (wr) begin
            case (da_reg)
               A_CSR: begin
                  twos_reg <= hwdata_in[CSR_TWOS];
                  scan_reg <= sadc_scan_t'(hwdata_in[CSR_SCAN +: 2]);
                  trig_reg <= sadc_trig_t'(hwdata_in[CSR_TRIG +: 2]);
                  irqen_reg <= hwdata_in[CSR_IRQEN];
                  mid_reg <= hwdata_in[CSR_MID];
                  cnten_reg <= hwdata_in[CSR_CNTEN];
                  gglb_reg <= hwdata_in[CSR_GGLB];
                  gx10_reg <= hwdata_in[CSR_GX10];
               end
               A_CCR: begin
                  blk_reg <= (hwdata_in[CCR_BLK +: 3] > BLK_RST) ? BLK_RST
                           : hwdata_in[CCR_BLK +: 3];
                  rch_reg <= hwdata_in[CCR_RCH +: 6];
               end
               // Never faster than the converter's aggregate ceiling
               A_RATE: rate_reg <= (hwdata_in[15:0] < RATE_RST) ? RATE_RST
                                 : hwdata_in[15:0];
               A_TIMER: timer_reg <= (hwdata_in > TIMER_MAX_US) ? TIMER_MAX_US
                                   : hwdata_in;
               A_COUNT: count_reg <= hwdata_in[15:0];
               A_VEC: begin
                  vec_reg <= hwdata_in[7:0];
                  lvl_reg <= (hwdata_in[VEC_LVL +: 3] == 3'h0) ? LVL_RST
                           : hwdata_in[VEC_LVL +: 3];
               end
               A_GAIN_LO: gain_reg[31:0] <= hwdata_in;
               A_GAIN_HI: gain_reg[63:32] <= hwdata_in;
               default: ;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Triggers: software, external edge, interval timer
   // ----------------------------------------
   assign tmr_exp = (pre_reg == 7'(TICK_CYC - 1)) && (tcnt_reg <= 32'h00000001);
   always_ff @(posedge ref_clk_in) begin
      if (rst) begin
         pre_reg <= 7'h00;
         tcnt_reg <= TIMER_RST;
         ext_q_reg <= 1'b0;
      end else if (ce_in) begin
         ext_q_reg <= ext_trig_in;
         pre_reg <= (pre_reg == 7'(TICK_CYC - 1)) ? 7'h00 : pre_reg + 7'h01;
         if (tmr_exp) begin
            tcnt_reg <= timer_reg;
         end else if (pre_reg == 7'(TICK_CYC - 1)) begin
            tcnt_reg <= tcnt_reg - 32'h00000001;
         end
      end
   end

   always_comb begin
      case (trig_reg)
         TRIG_FREE: trig = 1'b1;
         TRIG_SW: trig = start_reg;
         TRIG_EXT: trig = ext_trig_in && !ext_q_reg;
         TRIG_TIMER: trig = tmr_exp;
         default: trig = 1'b0;
      endcase
   end

   // ----------------------------------------
   // Scan sequencer
   // ----------------------------------------
   assign conv_ch = (scan_reg == SCAN_RANDOM) ? rch_reg : ch_reg;
   assign issue = st_reg == ST_IDLE && active_reg && pace_reg == 16'h0000;
   assign pass_end = st_reg == ST_CONV && conv_done_in
                  && (scan_reg == SCAN_RANDOM || ch_reg >= blk_last(blk_reg));
   assign buf_evt = pass_end && (pass_reg == 4'hF || (mid_reg && pass_reg == 4'h7));
   assign sample = twos_reg ? {~conv_data_in[15], conv_data_in[14:0]} : conv_data_in;
   assign cal_busy_out = st_reg == ST_CAL;
   assign conv_start_out = issue;

   always_ff @(posedge ref_clk_in) begin
      if (rst) begin
         st_reg <= ST_CAL;
         cal_reg <= 23'h000000;
         active_reg <= 1'b0;
         ch_reg <= 6'h00;
         pace_reg <= 16'h0000;
         pass_reg <= 4'h0;
         adc_cmd_out <= '0;
      end else if (ce_in) begin
         if (pace_reg != 16'h0000) begin
            pace_reg <= pace_reg - 16'h0001;
         end
         if (trig && st_reg != ST_CAL) begin
            active_reg <= 1'b1;
         end else if (pass_end && scan_reg != SCAN_AUTO) begin
            active_reg <= 1'b0;
         end
         case (st_reg)
            ST_CAL: begin
               if (cal_reg == 23'(CAL_CYCLES - 1)) begin
                  st_reg <= ST_IDLE;
               end else begin
                  cal_reg <= cal_reg + 23'h000001;
               end
            end
            ST_IDLE: begin
               if (issue) begin
                  pace_reg <= rate_reg - 16'h0001;
                  adc_cmd_out.chan <= conv_ch;
                  adc_cmd_out.gain_x10 <= gglb_reg ? gx10_reg : gain_reg[conv_ch];
                  st_reg <= ST_CONV;
               end
            end
            ST_CONV: begin
               if (conv_done_in) begin
                  st_reg <= ST_IDLE;
                  ch_reg <= pass_end ? 6'h00 : ch_reg + 6'h01;
                  if (pass_end) begin
                     pass_reg <= pass_reg + 4'h1;
                  end
               end
            end
            default: st_reg <= ST_CAL;
         endcase
      end
   end

   // ----------------------------------------
   // Sample store: 16-word ring per channel
   // ----------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (rst) begin
         for (int i = 0; i < 64; i++) begin
            wptr[i] <= 4'h0;
         end
      end else if (ce_in && st_reg == ST_CONV && conv_done_in) begin
         mem[{adc_cmd_out.chan, wptr[adc_cmd_out.chan]}] <= sample;
         wptr[adc_cmd_out.chan] <= wptr[adc_cmd_out.chan] + 4'h1;
      end
   end

   // ----------------------------------------
   // Flags, sample count, interrupter
   // ----------------------------------------
   assign cnt_evt = st_reg == ST_CONV && conv_done_in && cnten_reg
                 && count_reg != 16'h0000 && samp_reg + 16'h0001 == count_reg;
   assign irq_evt = (buf_evt && irqen_reg) || cnt_evt;
   assign ack = iack_in && iack_level_in == lvl_reg;
   assign irq_req_out = irq_reg;
   assign irq_level_out = lvl_reg;
   assign led_out = led_reg;

   // Buffer and interrupt events win over a clear in the same cycle
   always_ff @(posedge ref_clk_in) begin
      if (rst) begin
         rdy_reg <= 1'b0;
         led_reg <= 1'b1;
         irq_reg <= 1'b0;
         samp_reg <= 16'h0000;
         irq_vector_out <= VEC_RST;
      end else if (ce_in) begin
         irq_vector_out <= vec_reg;
         if (buf_evt) begin
            rdy_reg <= 1'b1;
         end else if (wr && da_reg == A_CSR && hwdata_in[CSR_RDY]) begin
            rdy_reg <= 1'b0;
         end
         if (wr && da_reg == A_CSR && hwdata_in[CSR_LED]) begin
            led_reg <= 1'b0;
         end
         // Count restarts on a new target, so old samples never count toward it
         if (wr && da_reg == A_COUNT) begin
            samp_reg <= 16'h0000;
         end else if (st_reg == ST_CONV && conv_done_in && cnten_reg) begin
            samp_reg <= cnt_evt ? 16'h0000 : samp_reg + 16'h0001;
         end
         if (irq_evt) begin
            irq_reg <= 1'b1;
         end else if (ack) begin
            irq_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   logic [15:0] gap_reg;
   always_ff @(posedge ref_clk_in) begin
      if (rst) begin
         gap_reg <= 16'hFFFF;
      end else if (issue) begin
         gap_reg <= 16'h0000;
      end else if (ce_in && gap_reg != 16'hFFFF) begin
         gap_reg <= gap_reg + 16'h0001;
      end
   end

   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst || !ce_in);

   property p_ack_release;
      ack && !irq_evt |=> !irq_req_out;
   endproperty
   a_ack_release: assert property (p_ack_release) else $error("irq not released");
   property p_buf_irq;
      buf_evt && irqen_reg |=> irq_req_out;
   endproperty
   a_buf_irq: assert property (p_buf_irq) else $error("buffer irq missing");
   property p_cnt_irq;
      cnt_evt |=> irq_req_out && samp_reg == 16'h0000;
   endproperty
   a_cnt_irq: assert property (p_cnt_irq) else $error("count irq missing");
   property p_vec;
      ##1 $stable(vec_reg) [*2] |-> irq_vector_out == vec_reg;
   endproperty
   a_vec: assert property (p_vec) else $error("vector mismatch");
   property p_ready;
      pass_end && pass_reg == 4'hF |=> rdy_reg;
   endproperty
   a_ready: assert property (p_ready) else $error("data ready not set");
   property p_cal;
      issue |-> !cal_busy_out && cal_reg == 23'(CAL_CYCLES - 1);
   endproperty
   a_cal: assert property (p_cal) else $error("conversion during calibration");
   property p_gain;
      issue && gglb_reg |=> adc_cmd_out.gain_x10 == $past(gx10_reg);
   endproperty
   a_gain: assert property (p_gain) else $error("global gain wrong");
   property p_rate;
      issue && $past(issue, 2) == 1'b0 |-> gap_reg == 16'h0000 || gap_reg >= RATE_RST - 16'h0001;
   endproperty
   a_rate: assert property (p_rate) else $error("conversions too close");
   property p_wrap;
      pass_end && scan_reg != SCAN_RANDOM |=> ch_reg == 6'h00;
   endproperty
   a_wrap: assert property (p_wrap) else $error("scan did not restart at zero");
   property p_led;
      led_reg && !(wr && da_reg == A_CSR) |=> led_reg;
   endproperty
   a_led: assert property (p_led) else $error("led cleared without write");

   c_pass: cover property (pass_end && scan_reg == SCAN_AUTO);
   c_irq_ack: cover property (irq_req_out ##[1:50] ack);
   c_single: cover property (pass_end && scan_reg == SCAN_SINGLE);
   c_ext: cover property (trig_reg == TRIG_EXT && trig);
endmodule : sadc_top
`default_nettype wire

// *** include/sadc_pkg.sv ***
// Shared constants and types for the scanning converter controller.
// Assumes a single 125 MHz clock and an AHB-Lite register bus.
package sadc_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_NS = 8;
   localparam int CAL_MS = 41;
   localparam int CAL_CYC = CAL_MS * 1000000 / CLK_NS;
   localparam int MAX_KSPS = 100;
   localparam int CONV_MIN_CYC = 1000000 / (MAX_KSPS * CLK_NS);
   localparam int TICK_NS = 1000;
   localparam int TICK_CYC = TICK_NS / CLK_NS;
   localparam int TIMER_MAX_S = 687;
   localparam logic [31:0] TIMER_MAX_US = 32'(TIMER_MAX_S * 1000000);
   // ----------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [12:0] A_CSR = 13'h0000;
   localparam logic [12:0] A_CCR = 13'h0004;
   localparam logic [12:0] A_RATE = 13'h0008;
   localparam logic [12:0] A_TIMER = 13'h000C;
   localparam logic [12:0] A_COUNT = 13'h0010;
   localparam logic [12:0] A_VEC = 13'h0014;
   localparam logic [12:0] A_GAIN_LO = 13'h0018;
   localparam logic [12:0] A_GAIN_HI = 13'h001C;
   localparam logic [12:0] A_BID = 13'h0020;
   localparam logic [12:0] A_SRST = 13'h0024;
   localparam logic [12:0] A_LATEST = 13'h0100;
   localparam logic [12:0] A_BUF = 13'h1000;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int CSR_RDY = 0;
   localparam int CSR_LED = 1;
   localparam int CSR_TWOS = 2;
   localparam int CSR_SCAN = 3;
   localparam int CSR_TRIG = 5;
   localparam int CSR_START = 7;
   localparam int CSR_CAL = 8;
   localparam int CSR_IRQEN = 9;
   localparam int CSR_MID = 10;
   localparam int CSR_CNTEN = 11;
   localparam int CSR_GGLB = 12;
   localparam int CSR_GX10 = 13;
   localparam int CCR_BLK = 0;
   localparam int CCR_RCH = 8;
   localparam int VEC_LVL = 8;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [2:0] BLK_RST = 3'h4;
   localparam logic [15:0] RATE_RST = 16'(CONV_MIN_CYC);
   localparam logic [31:0] TIMER_RST = 32'h000F4240;
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic [7:0] VEC_RST = 8'h00;
   localparam logic [2:0] LVL_RST = 3'h1;
   localparam logic [31:0] BOARD_ID_DEF = 32'h0000A5C3;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {SCAN_AUTO = 2'h0, SCAN_SINGLE = 2'h1,
                             SCAN_RANDOM = 2'h2} sadc_scan_t;
   typedef enum logic [1:0] {TRIG_FREE = 2'h0, TRIG_SW = 2'h1,
                             TRIG_EXT = 2'h2, TRIG_TIMER = 2'h3} sadc_trig_t;
   typedef enum logic [2:0] {ST_CAL = 3'b001, ST_IDLE = 3'b010,
                             ST_CONV = 3'b100} sadc_state_t;
   typedef struct packed {
      logic [5:0] chan;
      logic gain_x10;
   } sadc_cmd_t;
endpackage : sadc_pkg

// *** tb/sadc_conv_model.sv ***
// Behavioural converter that answers each start pulse with one done pulse and data.
// Assumes the command word is valid from the cycle after the start pulse.
`timescale 1ns/100ps
`default_nettype none
module sadc_conv_model (
   input wire logic clk_in,
   input wire logic slow_in,
   input wire logic conv_start_in,
   input wire sadc_pkg::sadc_cmd_t cmd_in,
   output logic done_out,
   output logic [15:0] data_out
);
   import sadc_pkg::*;
   int wait_cnt = 0;
   logic busy = 1'b0;
   logic [15:0] last = 16'h0000;
   logic [15:0] word;
   // Data carries channel and gain so the bench can see what was sampled
   assign word = {8'hC3, 1'b0, cmd_in.gain_x10, cmd_in.chan};
   initial done_out = 1'b0;
   initial data_out = 16'h0000;
   // Off the done pulse the data lines show the inverse, never a stale copy
   always @(posedge clk_in) begin
      done_out <= 1'b0;
      data_out <= ~last;
      if (conv_start_in) begin
         busy <= 1'b1;
         wait_cnt <= slow_in ? 40 : 2;
      end else if (busy && wait_cnt == 0) begin
         busy <= 1'b0;
         done_out <= 1'b1;
         data_out <= word;
         last <= word;
      end else if (busy) begin
         wait_cnt <= wait_cnt - 1;
      end
   end
endmodule : sadc_conv_model
`default_nettype wire

// *** tb/tb_scanning_adc_vme_controller.sv ***
// Directed testbench: bus read/write tasks and test sequences with expected values.
// Assumes sadc_pkg, sadc_top and the converter model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_scanning_adc_vme_controller;
   import sadc_pkg::*;
   localparam int CAL = 50;
   localparam logic [31:0] ID = 32'h00001234; // Arbitrary value
   logic ref_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h00000000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h00000000;
   logic [31:0] hrdata, rdata;
   logic hready, hresp, conv_start, conv_done, cal_busy, led, irq;
   logic [15:0] conv_data;
   logic [2:0] irq_level;
   logic [7:0] irq_vector;
   logic iack = 1'b0;
   logic [2:0] iack_level = 3'h0;
   logic slow = 1'b0;
   logic ext = 1'b0;
   sadc_cmd_t cmd;
   int error_cnt = 0;
   int num_checks = 0;
   always #4 ref_clk_in = ~ref_clk_in;
   sadc_top #(.CAL_CYCLES(CAL), .BOARD_ID(ID)) DUT (
      .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1), .hsel_in(hsel),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
      .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
      .hresp_out(hresp), .conv_start_out(conv_start), .adc_cmd_out(cmd),
      .conv_done_in(conv_done), .conv_data_in(conv_data), .ext_trig_in(ext),
      .cal_busy_out(cal_busy), .led_out(led), .irq_req_out(irq), .irq_level_out(irq_level),
      .iack_in(iack), .iack_level_in(iack_level), .irq_vector_out(irq_vector));
   sadc_conv_model CONV (.clk_in(ref_clk_in), .slow_in(slow), .conv_start_in(conv_start),
      .cmd_in(cmd), .done_out(conv_done), .data_out(conv_data));
   // ----------------------------------------
   // Bus and handshake tasks
   // ----------------------------------------
   task automatic xfer(input logic [12:0] a, input logic wr, input logic [31:0] d);
      int n;
      n = 0;
      haddr <= {19'h00000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      hsel <= 1'b1;
      do begin @(posedge ref_clk_in); n++; end while (hready !== 1'b1 && n < 100);
      htrans <= 2'h0;
      hwdata <= d;
      do begin @(posedge ref_clk_in); n++; end while (hready !== 1'b1 && n < 200);
      rdata = hrdata;
   endtask : xfer
   task automatic wait_start(output int n);
      n = 0;
      do begin @(posedge ref_clk_in); n++; end while (conv_start !== 1'b1 && n < 3000);
      @(posedge ref_clk_in);
   endtask : wait_start
   task automatic wait_irq(input int lim);
      int n;
      n = 0;
      while (irq !== 1'b1 && n < lim) begin @(posedge ref_clk_in); n++; end
   endtask : wait_irq
   task automatic ack(input logic [2:0] lvl);
      iack <= 1'b1;
      iack_level <= lvl;
      @(posedge ref_clk_in);
      iack <= 1'b0;
      repeat (2) @(posedge ref_clk_in);
   endtask : ack
   task automatic results();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : results
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      int n;
      repeat (4) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      `CHK("led", 1'b1, led)
      `CHK("cal_busy", 1'b1, cal_busy)
      `CHK("irq", 1'b0, irq)
      `CHK("level", 3'h1, irq_level)
      `CHK("vector", 8'h00, irq_vector)
      xfer(A_CSR, 1'b0, 32'h0);
      `CHK("csr_cal", 1'b1, rdata[CSR_CAL])
      `CHK("csr_mode", 4'h4, {rdata[13:12], rdata[4:3]})
      `CHK("hresp", 1'b0, hresp)
      n = 3;
      while (cal_busy !== 1'b0 && n < 200) begin @(posedge ref_clk_in); n++; end
      `CHK("cal_len", 1'b1, n >= CAL - 2 && n <= CAL + 4)
      wait_start(n);
      `CHK("chan_first", 6'h00, cmd.chan)
      `CHK("gain_rst", 1'b0, cmd.gain_x10)
      wait_start(n);
      `CHK("chan_next", 6'h01, cmd.chan)
      `CHK("spacing", 1'b1, n >= CONV_MIN_CYC - 1)
      xfer(A_BID, 1'b0, 32'h0);
      `CHK("bid", ID, rdata)
      xfer(A_BID, 1'b1, 32'h0);
      xfer(A_BID, 1'b0, 32'h0);
      `CHK("bid_ro", ID, rdata)
      xfer(A_CCR, 1'b0, 32'h0);
      `CHK("ccr_blk", BLK_RST, rdata[2:0])
      xfer(A_RATE, 1'b0, 32'h0);
      `CHK("rate", RATE_RST, rdata[15:0])
      xfer(13'h0200, 1'b0, 32'h0);
      `CHK("unmapped", 32'h00000000, rdata)
      xfer(A_CSR, 1'b1, 32'h00003002);
      wait_start(n);
      `CHK("led_clr", 1'b0, led)
      `CHK("gain_glb", 1'b1, cmd.gain_x10)
      xfer(A_CCR, 1'b1, 32'h0);
      xfer(A_VEC, 1'b1, 32'h0000035A);
      repeat (2) @(posedge ref_clk_in);
      `CHK("level_w", 3'h3, irq_level)
      `CHK("vector_w", 8'h5A, irq_vector)
      xfer(A_GAIN_LO, 1'b1, 32'h00000001);
      slow <= 1'b1;
      xfer(A_CSR, 1'b1, 32'h00000204);
      wait_start(n);
      wait_start(n);
      `CHK("chan_blk1", 6'h00, cmd.chan)
      `CHK("gain_ch", 1'b1, cmd.gain_x10)
      repeat (60) @(posedge ref_clk_in);
      xfer(A_LATEST, 1'b0, 32'h0);
      `CHK("latest", 32'h00004340, rdata)
      wait_irq(25000);
      `CHK("irq_end", 1'b1, irq)
      xfer(A_CSR, 1'b0, 32'h0);
      `CHK("rdy", 1'b1, rdata[CSR_RDY])
      ack(3'h2);
      `CHK("irq_keep", 1'b1, irq)
      ack(3'h3);
      `CHK("irq_rel", 1'b0, irq)
      xfer(A_CSR, 1'b1, 32'h00000205);
      xfer(A_CSR, 1'b0, 32'h0);
      `CHK("rdy_clr", 1'b0, rdata[CSR_RDY])
      xfer(A_COUNT, 1'b1, 32'h00000003);
      xfer(A_CSR, 1'b1, 32'h00000800);
      wait_irq(5000);
      `CHK("irq_cnt", 1'b1, irq)
      ack(3'h3);
      xfer(A_CSR, 1'b1, 32'h00000048);
      wait_start(n);
      wait_start(n);
      `CHK("single_stop", 3000, n)
      ext <= 1'b1;
      wait_start(n);
      ext <= 1'b0;
      `CHK("ext_start", 1'b1, n <= 4)
      xfer(A_SRST, 1'b1, 32'hFFFFFFFF);
      repeat (2) @(posedge ref_clk_in);
      `CHK("srst_led", 1'b1, led)
      `CHK("srst_cal", 1'b1, cal_busy)
      `CHK("srst_lvl", 3'h1, irq_level)
      xfer(A_CCR, 1'b0, 32'h0);
      `CHK("srst_blk", BLK_RST, rdata[2:0])
      results();
   end
   // Whole run needs about 31000 cycles; this bound is well past it
   initial begin
      repeat (80000) @(posedge ref_clk_in);
      error_cnt++;
      results();
   end
endmodule : tb_scanning_adc_vme_controller
`default_nettype wire
